// ==== cpwt_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the pulse/warm-up timer
`ifndef CPWT_CFG_SVH
`define CPWT_CFG_SVH

// Byte offsets on the AHB-Lite register bus
`define CPWT_OFS_LOWER_CTRL    8'h00
`define CPWT_OFS_UPPER_CTRL    8'h04
`define CPWT_OFS_WIDTH_LOW     8'h08
`define CPWT_OFS_WIDTH_HIGH    8'h0c
`define CPWT_OFS_PERIOD_LOW    8'h10
`define CPWT_OFS_PERIOD_HIGH   8'h14
`define CPWT_OFS_STATUS        8'h18
`define CPWT_OFS_COUNT         8'h1c

// Lower timer control fields
`define CPWT_LTC_PRESCALE_LSB  0
`define CPWT_LTC_PRESCALE_MSB  1
`define CPWT_LTC_EXT_SEL       2

// Upper timer control fields
`define CPWT_UTC_RUN           0
`define CPWT_UTC_INIT_LEVEL    1
`define CPWT_UTC_MODE_LSB      2
`define CPWT_UTC_MODE_MSB      3

// Status fields
`define CPWT_ST_IRQ_FLAG       0
`define CPWT_ST_TOGGLE_FLOP    1

// Mode codes in the upper timer control
`define CPWT_MODE_PULSE        2'h0
`define CPWT_MODE_WARM_LOW     2'h1
`define CPWT_MODE_WARM_HIGH    2'h2

// Prescaler taps: internal clock divided by 2^3, 2^5, 2^7, 2^11
`define CPWT_PRE_DIV0          11'h007
`define CPWT_PRE_DIV1          11'h01f
`define CPWT_PRE_DIV2          11'h07f
`define CPWT_PRE_DIV3          11'h7ff

// Register reset values
`define CPWT_RST_BYTE          8'h00

// Pin levels: two machine cycles each, a machine cycle being four clocks
`define CPWT_MACHINE_CLKS      4
`define CPWT_MIN_LEVEL_MC      2
`define CPWT_MIN_LEVEL_CLKS    (`CPWT_MACHINE_CLKS * `CPWT_MIN_LEVEL_MC)

// Smallest warm-up target high byte
`define CPWT_WARM_MIN_HIGH     8'h01

`endif

// ==== cpwt_pin_filter.sv ====
// Two-flop synchroniser and minimum-level filter giving a falling-edge tick
`include "cpwt_cfg.svh"

module cpwt_pin_filter #(
  parameter int MIN_CLKS = `CPWT_MIN_LEVEL_CLKS
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      fall_tick
);

  cpwt_pkg::cpwt_filt_state_t st_reg;
  cpwt_pkg::cpwt_filt_state_t st_next;

  // Level only moves after it has stood MIN_CLKS cycles; glitches shorter than that vanish
  always_comb begin
    st_next      = st_reg;
    st_next.s1   = pin_in;
    st_next.s2   = st_reg.s1;
    st_next.tick = 1'b0;
    if (st_reg.s2 != st_reg.level) begin
      if (st_reg.cnt == 4'(MIN_CLKS - 1)) begin
        st_next.level = st_reg.s2;
        st_next.cnt   = 4'h0;
        st_next.tick  = ~st_reg.s2;
      end else begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end else begin
      st_next.cnt = 4'h0;
    end
  end

  // Filtered level idles high so the first real fall counts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: 4'h0, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign fall_tick = st_reg.tick;

endmodule : cpwt_pin_filter

// ==== cpwt_pkg.sv ====
// Types shared by the pulse/warm-up timer modules
package cpwt_pkg;

  // Complete state of the pin filter
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       level;
    logic [3:0] cnt;
    logic       tick;
  } cpwt_filt_state_t;

  // Complete state of the timer core and its bus slave
  typedef struct packed {
    logic [7:0]  lower_timer_control;
    logic [7:0]  upper_timer_control;
    logic [7:0]  width_compare_low;
    logic [7:0]  width_compare_high;
    logic [7:0]  period_compare_low;
    logic [7:0]  period_compare_high;
    logic [7:0]  lower_timer_stage;
    logic [7:0]  upper_timer_stage;
    logic        pulse_toggle_flop;
    logic        pin;
    logic        irq_pulse;
    logic        irq_flag;
    logic [10:0] pre;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
  } cpwt_state_t;

endpackage : cpwt_pkg

// ==== cpwt_pulse_src.sv ====
// External square-wave source driving a counter input pin
module cpwt_pulse_src (
  input wire logic       clk,
  input wire logic       en,
  input wire logic [7:0] half,
  output logic           pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;

  initial begin
    pin = 1'b1;
    cnt = 8'h00;
  end

  // Idle high when off, like a pulled-up line; each level lasts half clocks
  always @(posedge clk) begin
    if (!en) begin
      pin <= 1'b1;
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= half) begin
      pin <= ~pin;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : cpwt_pulse_src

// ==== cpwt_timer.sv ====
// Cascaded 16-bit pulse generator and warm-up counter with an AHB-Lite register slave
// How it works
// - Two byte stages count up as one 16-bit counter from prescaler or pin, or on every clock in high-frequency warm-up
// - Match with width compare inverts the toggle flop; counting continues
// - Match with period compare inverts flop, clears counter, raises upper timer irq
// - Pin clock levels shorter than two machine cycles are not counted
// - Toggle flop takes its start level from software bit; reset clears it
// - Pulse pin always shows the inverse of the toggle flop
// - Compare registers have no shadow; writes act at once
// - Stop freezes the pin; later initial-level write moves it; never both at once
// - Warm-up match uses only the high byte of the period compare
// - After start in warm-up, a match raises the irq and clears the counter
// - Warm-up targets span 0100h to ff00h, low byte forced to zero
// - High-frequency warm-up counts every clock, 256 counts per high-byte step
// - Counter runs while the run bit is one and stops when it is cleared
`include "cpwt_cfg.svh"

module cpwt_timer #(
  parameter int MIN_LEVEL_CLKS = `CPWT_MIN_LEVEL_CLKS
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pins
  input  wire logic        ext_clk_pin,
  input  wire logic        low_freq_clock,
  output logic             pulse_out_pin,
  output logic             upper_timer_irq,
  output logic             pulse_toggle_flop
);

  cpwt_pkg::cpwt_state_t st_reg;
  cpwt_pkg::cpwt_state_t st_next;

  logic ext_tick;
  logic low_tick;

  // External counter clock pin, synchronised and width filtered
  cpwt_pin_filter #(
    .MIN_CLKS (MIN_LEVEL_CLKS)
  ) u_ext_filter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (ext_clk_pin),
    .fall_tick (ext_tick)
  );

  // Low-frequency clock, used as the count source in low warm-up
  cpwt_pin_filter #(
    .MIN_CLKS (MIN_LEVEL_CLKS)
  ) u_low_filter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (low_freq_clock),
    .fall_tick (low_tick)
  );

  // Decoded views of the registers and of the bus request
  logic        run;
  logic [1:0]  mode;
  logic        warm;
  logic [15:0] count;
  logic [15:0] count_inc;
  logic [15:0] width_val;
  logic [15:0] period_val;
  logic [7:0]  warm_high;
  logic [15:0] warm_val;
  logic        pre_tick;
  logic        cnt_tick;
  logic        addr_take;

  assign run        = st_reg.upper_timer_control[`CPWT_UTC_RUN];
  assign mode       = st_reg.upper_timer_control[`CPWT_UTC_MODE_MSB:`CPWT_UTC_MODE_LSB];
  assign warm       = (mode == `CPWT_MODE_WARM_LOW) || (mode == `CPWT_MODE_WARM_HIGH);
  assign count      = {st_reg.upper_timer_stage, st_reg.lower_timer_stage};
  assign width_val  = {st_reg.width_compare_high, st_reg.width_compare_low};
  assign period_val = {st_reg.period_compare_high, st_reg.period_compare_low};
  assign addr_take  = hsel && hready && htrans[1];

  // Target below 0100h is lifted so a warm-up can never end instantly
  assign warm_high = (st_reg.period_compare_high < `CPWT_WARM_MIN_HIGH) ?
                     `CPWT_WARM_MIN_HIGH : st_reg.period_compare_high;
  assign warm_val  = {warm_high, 8'h00};

  // Carry from low stage into high stage only on a low-stage wrap
  assign count_inc = {st_reg.upper_timer_stage + ((st_reg.lower_timer_stage == 8'hff) ? 8'h01 : 8'h00),
                      st_reg.lower_timer_stage + 8'h01};

  // Prescaler tap chosen by the lower control register
  always_comb begin
    unique case (st_reg.lower_timer_control[`CPWT_LTC_PRESCALE_MSB:`CPWT_LTC_PRESCALE_LSB])
      2'h0: pre_tick = (st_reg.pre[2:0] == `CPWT_PRE_DIV0);
      2'h1: pre_tick = (st_reg.pre[4:0] == `CPWT_PRE_DIV1);
      2'h2: pre_tick = (st_reg.pre[6:0] == `CPWT_PRE_DIV2);
      2'h3: pre_tick = (st_reg.pre == `CPWT_PRE_DIV3);
    endcase
  end

  // Count source: warm-up modes use their oscillator, pulse mode prescaler or pin
  always_comb begin
    unique case (mode)
      `CPWT_MODE_WARM_LOW:  cnt_tick = low_tick;
      `CPWT_MODE_WARM_HIGH: cnt_tick = 1'b1;
      default: cnt_tick = st_reg.lower_timer_control[`CPWT_LTC_EXT_SEL] ? ext_tick : pre_tick;
    endcase
  end

  // All next-state logic: counter, toggle flop, bus slave
  always_comb begin
    st_next           = st_reg;
    st_next.pre       = st_reg.pre + 11'h001;
    st_next.irq_pulse = 1'b0;

    // Counting only while the run bit is set; a stop freezes count and pin
    if (run && cnt_tick) begin
      if (warm) begin
        if (count_inc == warm_val) begin
          st_next.lower_timer_stage = 8'h00;
          st_next.upper_timer_stage = 8'h00;
          st_next.irq_pulse         = 1'b1;
        end else begin
          st_next.lower_timer_stage = count_inc[7:0];
          st_next.upper_timer_stage = count_inc[15:8];
        end
      end else if (count_inc == period_val) begin
        st_next.lower_timer_stage = 8'h00;
        st_next.upper_timer_stage = 8'h00;
        st_next.pulse_toggle_flop = ~st_reg.pulse_toggle_flop;
        st_next.irq_pulse         = 1'b1;
      end else begin
        st_next.lower_timer_stage = count_inc[7:0];
        st_next.upper_timer_stage = count_inc[15:8];
        if (count_inc == width_val) begin
          st_next.pulse_toggle_flop = ~st_reg.pulse_toggle_flop;
        end
      end
    end

    // Data phase of a write; the address phase was captured a cycle earlier
    if (st_reg.ap_valid && st_reg.ap_write) begin
      unique case (st_reg.ap_addr)
        `CPWT_OFS_LOWER_CTRL: st_next.lower_timer_control = hwdata[7:0];
        `CPWT_OFS_UPPER_CTRL: begin
          st_next.upper_timer_control = hwdata[7:0];
          // Initial level loads only while stopped, so a stopping write keeps the pin
          if (!run) begin
            st_next.pulse_toggle_flop = hwdata[`CPWT_UTC_INIT_LEVEL];
          end
          // A fresh start counts from zero
          if (!run && hwdata[`CPWT_UTC_RUN]) begin
            st_next.lower_timer_stage = 8'h00;
            st_next.upper_timer_stage = 8'h00;
          end
        end
        `CPWT_OFS_WIDTH_LOW:   st_next.width_compare_low   = hwdata[7:0];
        `CPWT_OFS_WIDTH_HIGH:  st_next.width_compare_high  = hwdata[7:0];
        `CPWT_OFS_PERIOD_LOW:  st_next.period_compare_low  = hwdata[7:0];
        `CPWT_OFS_PERIOD_HIGH: st_next.period_compare_high = hwdata[7:0];
        default: ;
      endcase
    end

    // Status flag: write one clears, but a match in the same cycle wins
    if (st_reg.ap_valid && st_reg.ap_write && (st_reg.ap_addr == `CPWT_OFS_STATUS) &&
        hwdata[`CPWT_ST_IRQ_FLAG]) begin
      st_next.irq_flag = 1'b0;
    end
    if (st_next.irq_pulse) begin
      st_next.irq_flag = 1'b1;
    end

    // Pin register follows the flop inverted
    st_next.pin = ~st_next.pulse_toggle_flop;

    // Address phase capture; read data prepared now so it stands in the data phase
    st_next.ap_valid = addr_take;
    st_next.ap_write = hwrite;
    st_next.ap_addr  = haddr[7:0];
    if (addr_take && !hwrite) begin
      unique case (haddr[7:0])
        `CPWT_OFS_LOWER_CTRL:  st_next.rdata = {24'h000000, st_reg.lower_timer_control};
        `CPWT_OFS_UPPER_CTRL:  st_next.rdata = {24'h000000, st_reg.upper_timer_control};
        `CPWT_OFS_WIDTH_LOW:   st_next.rdata = {24'h000000, st_reg.width_compare_low};
        `CPWT_OFS_WIDTH_HIGH:  st_next.rdata = {24'h000000, st_reg.width_compare_high};
        `CPWT_OFS_PERIOD_LOW:  st_next.rdata = {24'h000000, st_reg.period_compare_low};
        `CPWT_OFS_PERIOD_HIGH: st_next.rdata = {24'h000000, st_reg.period_compare_high};
        `CPWT_OFS_STATUS:      st_next.rdata = {30'h0, st_reg.pulse_toggle_flop, st_reg.irq_flag};
        `CPWT_OFS_COUNT:       st_next.rdata = {16'h0000, count};
        default:               st_next.rdata = 32'h00000000;
      endcase
    end
  end

  // Reset clears every register except the pin, which is loaded high to match the flop at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg     <= '0;
      st_reg.pin <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave: word transfers only, size is not checked
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = st_reg.rdata;
  assign pulse_out_pin     = st_reg.pin;
  assign upper_timer_irq   = st_reg.irq_pulse;
  assign pulse_toggle_flop = st_reg.pulse_toggle_flop;

endmodule : cpwt_timer

// ==== cpwt_timer_asserts.sv ====
// Concurrent checks on the ports of the pulse/warm-up timer
`include "cpwt_cfg.svh"

module cpwt_timer_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        pulse_out_pin,
  input wire logic        upper_timer_irq,
  input wire logic        pulse_toggle_flop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       dp_reg;
  logic [3:0] ctl_reg;

  // Shadow of upper control writes, so run and mode are known without peeking inside
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_reg  <= 1'b0;
      ctl_reg <= 4'h0;
    end else begin
      dp_reg <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == `CPWT_OFS_UPPER_CTRL;
      if (dp_reg) begin
        ctl_reg <= hwdata[3:0];
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rst_clear;
    $fell(sys_rst) |-> !pulse_toggle_flop && pulse_out_pin && !upper_timer_irq;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("flop, pin or irq wrong after reset");
  property p_pin_inv;
    pulse_out_pin == !pulse_toggle_flop;
  endproperty
  a_pin_inv: assert property (p_pin_inv)
    else $error("pulse pin is not the inverse of the flop");
  property p_irq_one;
    upper_timer_irq |=> !upper_timer_irq;
  endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("irq longer than one cycle");
  // A period match in pulse mode toggles the flop in the cycle of the irq or in the cycle before it
  property p_pulse_irq;
    upper_timer_irq && !(^ctl_reg[3:2]) |-> $changed(pulse_toggle_flop)
      || $past(pulse_toggle_flop) != $past(pulse_toggle_flop, 2);
  endproperty
  a_pulse_irq: assert property (p_pulse_irq)
    else $error("period irq without flop toggle");
  property p_warm_irq;
    upper_timer_irq && (^ctl_reg[3:2]) |-> $stable(pulse_toggle_flop);
  endproperty
  a_warm_irq: assert property (p_warm_irq)
    else $error("flop moved on a warm-up match");
  property p_stopped_quiet;
    !ctl_reg[0] && !$past(ctl_reg[0]) |-> !upper_timer_irq;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet)
    else $error("irq while stopped");
  property p_frozen;
    !ctl_reg[0] && !dp_reg |=> $stable(pulse_toggle_flop);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("flop moved while stopped");
  property p_load;
    dp_reg && !ctl_reg[0] |=> pulse_toggle_flop == $past(hwdata[1]);
  endproperty
  a_load: assert property (p_load)
    else $error("flop did not take the initial level");
endmodule : cpwt_timer_asserts

bind cpwt_timer cpwt_timer_asserts i_cpwt_timer_asserts (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .pulse_out_pin(pulse_out_pin), .upper_timer_irq(upper_timer_irq), .pulse_toggle_flop(pulse_toggle_flop));

// ==== test_cpwt_timer.sv ====
// Self-checking bench for the pulse/warm-up timer
module test_cpwt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, ext_en, low_en;
  logic        ext_clk_pin, low_freq_clock, pulse_out_pin, upper_timer_irq, pulse_toggle_flop;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [7:0]  ext_half;
  int          fails, checks_done, seed, p, w, n;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  cpwt_timer i_cpwt_timer (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ext_clk_pin(ext_clk_pin), .low_freq_clock(low_freq_clock), .pulse_out_pin(pulse_out_pin),
    .upper_timer_irq(upper_timer_irq), .pulse_toggle_flop(pulse_toggle_flop));
  cpwt_pulse_src i_cpwt_pulse_src (.clk(clk), .en(ext_en), .half(ext_half), .pin(ext_clk_pin));
  cpwt_pulse_src i_cpwt_pulse_src_low (.clk(clk), .en(low_en), .half(8'h08), .pin(low_freq_clock));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Bounded wait for hready; the slave answers at once but no latency is assumed
  task automatic hs;
    int k;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    // A slave that never answers ends the run here
    if (k == 16) begin
      chk("bus ready", 0, 1);
      close_out;
    end
  endtask : hs

  task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w_en;
    hs;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hs;
    v = hrdata;
    chk("bus response", hresp, 0);
  endtask : bus

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask : rd_reg

  // Wait at falling edges, where outputs have settled, until the chosen output reaches lv
  task automatic wt(input bit fl, input logic lv, output int c);
    logic s;
    c = 0;
    do begin
      @(negedge clk);
      s = fl ? pulse_toggle_flop : upper_timer_irq;
      c++;
    end while (s !== lv && c < 9000);
    // An output that never moves is a hang; report and stop
    if (s !== lv) begin
      chk("wait bound", 0, 1);
      close_out;
    end
  endtask : wt

  // Flop high width, or gap between two irq pulses, in clocks
  task automatic span(input bit fl, input logic back, input int exp_c);
    int c;
    wt(fl, 1'b0, c);
    wt(fl, 1'b1, c);
    wt(fl, back, c);
    chk(fl ? "flop high width" : "irq gap", c, exp_c);
  endtask : span

  initial begin
    seed = 32'h16b5;
    fails = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext_en = 1'b0;
    low_en = 1'b0;
    ext_half = 8'h0a;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("flop after reset", pulse_toggle_flop, 0);
    chk("pin after reset", pulse_out_pin, 1);
    // All places read zero after reset; the unmapped one ignores its write
    wr_reg(8'h20, $random(seed));
    for (n = 0; n <= 32; n += 4) rd_reg(8'(n), 32'h0);
    // Compares have no shadow, so a read right after the write sees the new byte
    for (n = 8; n < 24; n += 4) begin
      q = {24'h0, 8'($random(seed))};
      wr_reg(8'(n), q);
      rd_reg(8'(n), q);
    end
    // Pulse mode on clock/8: a fixed corner first, then random width and period
    // The shared port latch sits outside this block; the bench treats it as set to one
    wr_reg(8'h00, 32'h0);
    for (n = 0; n < 4; n++) begin
      p = n ? 4 + $unsigned($random(seed)) % 8 : 5;
      w = n ? 1 + $unsigned($random(seed)) % (p - 1) : 3;
      wr_reg(8'h04, 32'h0);
      wr_reg(8'h08, 32'(w));
      wr_reg(8'h0c, 32'h0);
      wr_reg(8'h10, 32'(p));
      wr_reg(8'h14, 32'h0);
      wr_reg(8'h04, 32'h1);
      span(1, 0, (p - w) * 8);
      span(0, 1, p * 8);
    end
    // Level bit in the stopping access is refused; a later one moves the pin
    wr_reg(8'h04, 32'h2);
    @(negedge clk);
    chk("flop after stop", pulse_toggle_flop, 0);
    // The stop lands before the next prescaler tick, so the count stays at zero
    repeat (20) @(posedge clk);
    rd_reg(8'h1c, 32'h0);
    wr_reg(8'h04, 32'h2);
    @(negedge clk);
    chk("flop after level write", pulse_toggle_flop, 1);
    chk("pin after level write", pulse_out_pin, 0);
    // Pin clock with 10-clock levels is counted
    wr_reg(8'h00, 32'h4);
    wr_reg(8'h08, 32'h2);
    wr_reg(8'h10, 32'h4);
    ext_en <= 1'b1;
    wr_reg(8'h04, 32'h1);
    span(0, 1, 80);
    // Three-clock levels are too short to count
    wr_reg(8'h04, 32'h0);
    ext_half <= 8'h03;
    wr_reg(8'h04, 32'h1);
    for (n = 0; n < 300 && upper_timer_irq !== 1'b1; n++) @(negedge clk);
    chk("irq from short levels", n, 300);
    ext_en <= 1'b0;
    // Fast warm-up: random low period byte is ignored, 256 clocks per high step
    for (n = 1; n < 3; n++) begin
      wr_reg(8'h04, 32'h0);
      wr_reg(8'h10, $random(seed));
      wr_reg(8'h14, 32'(n));
      wr_reg(8'h04, 32'h9);
      span(0, 1, 256 * n);
    end
    // Slow warm-up from the low clock pin at the minimum level length
    wr_reg(8'h04, 32'h0);
    low_en <= 1'b1;
    wr_reg(8'h14, 32'h1);
    wr_reg(8'h04, 32'h5);
    span(0, 1, 4096);
    wr_reg(8'h04, 32'h0);
    rd_reg(8'h18, 32'h1);
    wr_reg(8'h18, 32'h1);
    rd_reg(8'h18, 32'h0);
    close_out;
  end
endmodule : test_cpwt_timer
